// [design/adc_trig_pkg.sv]
// What this block does
// - Special trigger in mode 1011 with converter on starts conversion.
// - Every special trigger clears the sixteen bit timer.
// - Trigger with converter off leaves go flag alone.
// - Unimplemented register bits read back as zero.
// - Conversion lasts nine and a half bit periods.
// - Bit period is 2, 8, 32 oscillator periods or RC.
// - Finished conversion clears go and loads result.
// - Software abort keeps result, waits two bit periods.
`default_nettype none
package adc_trig_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFF_PORT_A     = 8'h05;
  localparam logic [7:0] OFF_PORT_E     = 8'h09;
  localparam logic [7:0] OFF_INTERRUPT_CONTROL     = 8'h0b;
  localparam logic [7:0] OFF_FLAGS1     = 8'h0c;
  localparam logic [7:0] OFF_FLAGS2     = 8'h0d;
  localparam logic [7:0] OFF_RESULT     = 8'h1e;
  localparam logic [7:0] OFF_CONTROL    = 8'h1f;
  localparam logic [7:0] OFF_DIR_A      = 8'h85;
  localparam logic [7:0] OFF_DIR_E      = 8'h89;
  localparam logic [7:0] OFF_ENABLES1   = 8'h8c;
  localparam logic [7:0] OFF_ENABLES2   = 8'h8d;
  localparam logic [7:0] OFF_PIN_SETUP  = 8'h9f;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL     = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_RESULT     = 8'h00;
  localparam logic [5:0] RST_DIR_A      = 6'h3f;
  localparam logic [2:0] RST_DIR_E      = 3'h7;
  localparam logic [2:0] RST_PIN_SETUP  = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  localparam int CTL_ON_BIT     = 0;
  localparam int CTL_GO_BIT     = 2;
  localparam int CTL_CHAN_LSB   = 3;
  localparam int CTL_CLK_LSB    = 6;
  localparam int FLAG_DONE_BIT  = 6;
  localparam int FLAG_PAR_BIT   = 7;

  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;
  localparam logic [1:0] CLK_SEL_OSC2       = 2'h0;
  localparam logic [1:0] CLK_SEL_OSC8       = 2'h1;
  localparam logic [1:0] CLK_SEL_OSC32      = 2'h2;
  localparam logic [1:0] CLK_SEL_RC         = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TAD_OSC_SHORT  = 2;
  localparam int TAD_OSC_MID    = 8;
  localparam int TAD_OSC_LONG   = 32;
  localparam int RC_PERIOD_NS   = 4000;
  localparam logic [6:0] HALF_TAD_SHORT = 7'(TAD_OSC_SHORT / 2);
  localparam logic [6:0] HALF_TAD_MID   = 7'(TAD_OSC_MID / 2);
  localparam logic [6:0] HALF_TAD_LONG  = 7'(TAD_OSC_LONG / 2);
  localparam logic [6:0] HALF_TAD_RC    = 7'(RC_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [4:0] FIRST_DECISION = 5'h03;
  localparam logic [4:0] CONV_LAST_HALF = 5'h12;
  localparam logic [2:0] ABORT_HALVES   = 3'h4;
  localparam logic [7:0] FIRST_TRIAL    = 8'h80;

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_ABORT_WAIT} conv_state_t;

endpackage
`default_nettype wire

// [design/conv_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic [1:0] clock_sel;
  logic       run;
  logic       half_tick;
  logic       start;
  logic       abort;
  logic       comparator;
  logic [7:0] code;
  logic       done;
  modport ctrl   (output clock_sel, run, start, abort, comparator,
                  input half_tick, code, done);
  modport timer  (input clock_sel, run, start, output half_tick);
  modport engine (input start, abort, half_tick, comparator, output code, done);
endinterface
`default_nettype wire

// [design/bit_period_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bit_period_timer (
  input wire logic mclk_i,
  input wire logic rst_i,
  conv_if.timer    c
);
  logic [6:0] count;
  logic [6:0] target;

  always_comb begin
    case (c.clock_sel)
      adc_trig_pkg::CLK_SEL_OSC2:  target = adc_trig_pkg::HALF_TAD_SHORT;
      adc_trig_pkg::CLK_SEL_OSC8:  target = adc_trig_pkg::HALF_TAD_MID;
      adc_trig_pkg::CLK_SEL_OSC32: target = adc_trig_pkg::HALF_TAD_LONG;
      default:                     target = adc_trig_pkg::HALF_TAD_RC;
    endcase
  end

  // Half periods keep the 9.5 period figure exact in whole ticks.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count       <= 7'h00;
      c.half_tick <= 1'b0;
    end else if (!c.run || c.start) begin
      count       <= 7'h00;
      c.half_tick <= 1'b0;
    end else if (count == target - 7'h01) begin
      count       <= 7'h00;
      c.half_tick <= 1'b1;
    end else begin
      count       <= count + 7'h01;
      c.half_tick <= 1'b0;
    end
  end
endmodule // bit_period_timer
`default_nettype wire

// [design/sar_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
  input wire logic mclk_i,
  input wire logic rst_i,
  conv_if.engine   c
);
  logic       active;
  logic [4:0] halves;
  logic [7:0] probe;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      active <= 1'b0;
      halves <= 5'h00;
      probe  <= 8'h00;
      c.code <= 8'h00;
      c.done <= 1'b0;
    end else begin
      c.done <= 1'b0;
      if (c.abort) begin
        active <= 1'b0;
      end else if (c.start) begin
        active <= 1'b1;
        halves <= 5'h00;
        probe  <= adc_trig_pkg::FIRST_TRIAL;
        c.code <= adc_trig_pkg::FIRST_TRIAL;
      end else if (active && c.half_tick) begin
        halves <= halves + 5'h01;
        if (halves[0] && halves >= adc_trig_pkg::FIRST_DECISION && probe != 8'h00) begin
          c.code <= (c.comparator ? c.code : (c.code & ~probe)) | (probe >> 1);
          probe  <= probe >> 1;
        end
        if (halves == adc_trig_pkg::CONV_LAST_HALF) begin
          active <= 1'b0;
          c.done <= 1'b1;
        end
      end
    end
  end
endmodule // sar_engine
`default_nettype wire

// [design/adc_event_trigger_control.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_event_trigger_control (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Compare unit and timer.
  input  wire logic [3:0] compare_unit_two_mode_i,
  input  wire logic       special_event_i,
  output logic            timer_clear_o,
  // Analog front end.
  input  wire logic       comparator_i,
  output logic      [7:0] dac_code_o,
  output logic      [2:0] input_channel_o,
  output logic            acquire_o,
  output logic      [7:0] analog_pins_o,
  // Port pins.
  input  wire logic [5:0] port_a_i,
  output logic      [5:0] port_a_o,
  output logic      [5:0] port_a_oe_o,
  input  wire logic [2:0] port_e_i,
  output logic      [2:0] port_e_o,
  output logic      [2:0] port_e_oe_o,
  // Other peripheral events and interrupt.
  input  wire logic [5:0] other_flags_i,
  input  wire logic       second_flag_i,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////
  conv_if c ();

  bit_period_timer u_timer (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .c      (c.timer)
  );

  sar_engine u_engine (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .c      (c.engine)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]                clock_sel;
  logic [2:0]                channel;
  logic                      go;
  logic                      conv_on;
  logic [7:0]                interrupt_control;
  logic [7:0]                flags1;
  logic                      flags2;
  logic [7:0]                enables1;
  logic                      enables2;
  logic [7:0]                result;
  logic [5:0]                dir_a;
  logic [2:0]                dir_e;
  logic [2:0]                pin_setup;
  logic [5:0]                latch_a;
  logic [2:0]                latch_e;
  logic [2:0]                abort_halves;
  adc_trig_pkg::conv_state_t state;

  logic       wr_ctl;
  logic       trig_start;
  logic       done_evt;
  logic [7:0] analog_mask;
  logic [5:0] analog_a;
  logic [7:0] flags1_set;
  logic [7:0] flags1_clr;

  ////////////////////////////////////////////////////////////////////////
  // Pin map order is RE2 RE1 RE0 RA5 RA3 RA2 RA1 RA0.
  function automatic logic [7:0] decode_pins(input logic [2:0] cfg);
    case (cfg)
      3'h0:    decode_pins = 8'hff;
      3'h1:    decode_pins = 8'hf7;
      3'h2:    decode_pins = 8'h1f;
      3'h3:    decode_pins = 8'h17;
      3'h4:    decode_pins = 8'h0b;
      3'h5:    decode_pins = 8'h03;
      default: decode_pins = 8'h00;
    endcase
  endfunction

  assign analog_mask = decode_pins(pin_setup);
  assign analog_a    = {analog_mask[4], 1'b0, analog_mask[3], analog_mask[2:0]};
  assign wr_ctl      = wr_i && (addr_i == adc_trig_pkg::OFF_CONTROL);
  assign done_evt    = c.done;

  // A trigger outside the special event mode, or with the converter off,
  // never reaches the go flag.
  assign trig_start  = special_event_i && conv_on
                       && (compare_unit_two_mode_i == adc_trig_pkg::SPECIAL_EVENT_MODE);

  ////////////////////////////////////////////////////////////////////////
  assign c.clock_sel  = clock_sel;
  // Dropping run for the abort cycle restarts the bit period count, so the wait is never short.
  assign c.run        = (state != adc_trig_pkg::ST_IDLE) && !c.abort;
  assign c.start      = (state == adc_trig_pkg::ST_IDLE) && go && conv_on;
  assign c.abort      = (state == adc_trig_pkg::ST_CONVERT) && !(go && conv_on);
  assign c.comparator = comparator_i;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_sel <= adc_trig_pkg::RST_CONTROL[adc_trig_pkg::CTL_CLK_LSB +: 2];
      channel   <= adc_trig_pkg::RST_CONTROL[adc_trig_pkg::CTL_CHAN_LSB +: 3];
      conv_on   <= adc_trig_pkg::RST_CONTROL[adc_trig_pkg::CTL_ON_BIT];
    end else if (wr_ctl) begin
      clock_sel <= wdata_i[adc_trig_pkg::CTL_CLK_LSB +: 2];
      channel   <= wdata_i[adc_trig_pkg::CTL_CHAN_LSB +: 3];
      conv_on   <= wdata_i[adc_trig_pkg::CTL_ON_BIT];
    end
  end

  // A trigger beats a software write, which beats the end of conversion.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      go <= adc_trig_pkg::RST_CONTROL[adc_trig_pkg::CTL_GO_BIT];
    end else if (trig_start) begin
      go <= 1'b1;
    end else if (wr_ctl) begin
      go <= wdata_i[adc_trig_pkg::CTL_GO_BIT] && wdata_i[adc_trig_pkg::CTL_ON_BIT];
    end else if (done_evt) begin
      go <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= adc_trig_pkg::ST_IDLE;
      abort_halves <= 3'h0;
    end else begin
      case (state)
        adc_trig_pkg::ST_IDLE: begin
          abort_halves <= 3'h0;
          if (c.start) begin
            state <= adc_trig_pkg::ST_CONVERT;
          end
        end
        adc_trig_pkg::ST_CONVERT: begin
          if (c.abort) begin
            state        <= adc_trig_pkg::ST_ABORT_WAIT;
            abort_halves <= 3'h0;
          end else if (done_evt) begin
            state <= adc_trig_pkg::ST_IDLE;
          end
        end
        adc_trig_pkg::ST_ABORT_WAIT: begin
          // With the converter still on, acquisition resumes by itself once two bit periods have passed.
          if (c.half_tick) begin
            if (abort_halves == adc_trig_pkg::ABORT_HALVES - 3'h1) begin
              state <= adc_trig_pkg::ST_IDLE;
            end
            abort_halves <= abort_halves + 3'h1;
          end
        end
        default: begin
          state <= adc_trig_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // An aborted conversion never reaches the result; only a finish does.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      result <= adc_trig_pkg::RST_RESULT;
    end else if (done_evt) begin
      result <= c.code;
    end else if (wr_i && addr_i == adc_trig_pkg::OFF_RESULT) begin
      result <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_clear_o <= 1'b0;
    end else begin
      timer_clear_o <= special_event_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The parallel port flag has no source here, so it always stays clear.
  assign flags1_set = {1'b0, done_evt, other_flags_i};
  assign flags1_clr = (wr_i && addr_i == adc_trig_pkg::OFF_FLAGS1) ? wdata_i : 8'h00;

  // Sets win over a write-one clear in the same cycle.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags1 <= adc_trig_pkg::RST_FLAGS;
    end else begin
      flags1 <= (flags1 & ~flags1_clr) | flags1_set;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags2 <= adc_trig_pkg::RST_FLAGS[0];
    end else if (second_flag_i) begin
      flags2 <= 1'b1;
    end else if (wr_i && addr_i == adc_trig_pkg::OFF_FLAGS2 && wdata_i[0]) begin
      flags2 <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      enables1 <= adc_trig_pkg::RST_FLAGS;
      enables2 <= adc_trig_pkg::RST_FLAGS[0];
      interrupt_control   <= adc_trig_pkg::RST_INTERRUPT_CONTROL;
    end else if (wr_i) begin
      if (addr_i == adc_trig_pkg::OFF_ENABLES1) begin
        enables1 <= wdata_i;
      end
      if (addr_i == adc_trig_pkg::OFF_ENABLES2) begin
        enables2 <= wdata_i[0];
      end
      if (addr_i == adc_trig_pkg::OFF_INTERRUPT_CONTROL) begin
        interrupt_control <= wdata_i;
      end
    end
  end

  // Registered, so the line follows the flags one cycle late.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (|(flags1 & enables1)) || (flags2 && enables2);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_a     <= adc_trig_pkg::RST_DIR_A;
      dir_e     <= adc_trig_pkg::RST_DIR_E;
      pin_setup <= adc_trig_pkg::RST_PIN_SETUP;
      latch_a   <= 6'h00;
      latch_e   <= 3'h0;
    end else if (wr_i) begin
      case (addr_i)
        adc_trig_pkg::OFF_DIR_A:     dir_a     <= wdata_i[5:0];
        adc_trig_pkg::OFF_DIR_E:     dir_e     <= wdata_i[2:0];
        adc_trig_pkg::OFF_PIN_SETUP: pin_setup <= wdata_i[2:0];
        adc_trig_pkg::OFF_PORT_A:    latch_a   <= wdata_i[5:0];
        adc_trig_pkg::OFF_PORT_E:    latch_e   <= wdata_i[2:0];
        default: begin
        end
      endcase
    end
  end

  // A set direction bit means input, which is also the undriven enable.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_o      <= 6'h00;
      port_a_oe_o   <= adc_trig_pkg::RST_DIR_A;
      port_e_o      <= 3'h0;
      port_e_oe_o   <= adc_trig_pkg::RST_DIR_E;
      analog_pins_o <= 8'hff;
    end else begin
      port_a_o      <= latch_a;
      port_a_oe_o   <= dir_a;
      port_e_o      <= latch_e;
      port_e_oe_o   <= dir_e;
      analog_pins_o <= analog_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_code_o      <= 8'h00;
      input_channel_o <= 3'h0;
      acquire_o       <= 1'b0;
    end else begin
      dac_code_o      <= c.code;
      input_channel_o <= channel;
      acquire_o       <= conv_on && (state == adc_trig_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog pins read low on the port; missing bits fill with zero.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        adc_trig_pkg::OFF_PORT_A:    rdata_o <= {2'h0, port_a_i & ~analog_a};
        adc_trig_pkg::OFF_PORT_E:    rdata_o <= {5'h00, port_e_i & ~analog_mask[7:5]};
        adc_trig_pkg::OFF_INTERRUPT_CONTROL:    rdata_o <= interrupt_control;
        adc_trig_pkg::OFF_FLAGS1:    rdata_o <= flags1;
        adc_trig_pkg::OFF_FLAGS2:    rdata_o <= {7'h00, flags2};
        adc_trig_pkg::OFF_RESULT:    rdata_o <= result;
        adc_trig_pkg::OFF_CONTROL:   rdata_o <= {clock_sel, channel, go, 1'b0, conv_on};
        adc_trig_pkg::OFF_DIR_A:     rdata_o <= {2'h0, dir_a};
        adc_trig_pkg::OFF_DIR_E:     rdata_o <= {5'h00, dir_e};
        adc_trig_pkg::OFF_ENABLES1:  rdata_o <= enables1;
        adc_trig_pkg::OFF_ENABLES2:  rdata_o <= {7'h00, enables2};
        adc_trig_pkg::OFF_PIN_SETUP: rdata_o <= {5'h00, pin_setup};
        default:                     rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // adc_event_trigger_control
`default_nettype wire

// [test/adc_trig_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_trig_monitor (
  // Clock and reset.
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Trigger and converter.
  input wire logic [3:0] compare_unit_two_mode_i,
  input wire logic       special_event_i,
  input wire logic       timer_clear_o,
  input wire logic [7:0] dac_code_o,
  input wire logic       acquire_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  AST_TRIG_CLEAR: assert property (special_event_i |=> timer_clear_o)
    else $error("timer clear missing after trigger");
  AST_CLEAR_CAUSE: assert property (timer_clear_o |-> $past(special_event_i))
    else $error("timer clear without trigger");
  AST_TRIG_START: assert property (acquire_o && special_event_i &&
    compare_unit_two_mode_i == adc_trig_pkg::SPECIAL_EVENT_MODE |-> ##[1:4] !acquire_o)
    else $error("accepted trigger did not start a conversion");
  AST_FIRST_TRIAL: assert property ($fell(acquire_o) && !$past(wr_i) &&
    !$past(wr_i, 2) |-> ##[0:3] dac_code_o == adc_trig_pkg::FIRST_TRIAL)
    else $error("conversion did not begin at mid scale");
  AST_MIN_BUSY: assert property ($fell(acquire_o) |-> !acquire_o [*4])
    else $error("converter returned to acquisition too early");
  AST_SETUP_ZERO: assert property (rd_i && addr_i == adc_trig_pkg::OFF_PIN_SETUP
    |=> rdata_o[7:3] == 5'h00)
    else $error("pin setup upper bits not zero");
  AST_CTRL_GAP: assert property (rd_i && addr_i == adc_trig_pkg::OFF_CONTROL
    |=> !rdata_o[1])
    else $error("control bit one not zero");
  AST_FLAG_TOP: assert property (rd_i && addr_i == adc_trig_pkg::OFF_FLAGS1
    |=> !rdata_o[adc_trig_pkg::FLAG_PAR_BIT])
    else $error("reserved flag bit not zero");
  AST_FLAG2_TOP: assert property (rd_i && addr_i == adc_trig_pkg::OFF_FLAGS2
    |=> rdata_o[7:1] == 7'h00)
    else $error("second flag register upper bits not zero");
  AST_IRQ_STICKY: assert property ($fell(irq_o) |->
    $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("interrupt dropped without software write");

  ////////////////////////////////////////////////////////////////////////
  COV_TRIG: cover property (acquire_o && special_event_i);
  COV_IRQ: cover property ($rose(irq_o));
  COV_IGNORED: cover property (special_event_i && !acquire_o);
endmodule // adc_trig_monitor

bind adc_event_trigger_control adc_trig_monitor i_adc_trig_monitor (
  .mclk_i, .rst_i, .addr_i, .wr_i, .rd_i, .rdata_o, .compare_unit_two_mode_i,
  .special_event_i, .timer_clear_o, .dac_code_o, .acquire_o, .irq_o);
`default_nettype wire

// [test/compare_unit_model.sv]
`timescale 1ns/1ps
`default_nettype none
module compare_unit_model (
  // Clock and control.
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        enable_i,
  input  wire logic [15:0] period_i,
  input  wire logic [7:0]  level_i,
  // Block side.
  input  wire logic        timer_clear_i,
  input  wire logic [7:0]  dac_code_i,
  output logic             special_event_o,
  output logic             comparator_o,
  output logic [15:0]      count_o
);
  // The count only restarts through the block, so a missing clear shows as a large count.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) count_o <= 16'h0000;
    else if (timer_clear_i) count_o <= 16'h0000;
    else if (enable_i) count_o <= count_o + 16'h0001;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) special_event_o <= 1'b0;
    else special_event_o <= enable_i && (count_o == period_i);
  end

  assign comparator_o = (level_i >= dac_code_i);
endmodule // compare_unit_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} row_t;
  logic        mclk_i;
  logic        rst_i;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [3:0]  mode;
  logic        event_p;
  logic        tclr;
  logic        comp;
  logic [7:0]  dac;
  logic [2:0]  chan;
  logic        acq;
  logic [5:0]  oflags;
  logic        sflag;
  logic        irq;
  logic        en;
  logic [7:0]  level;
  logic [15:0] count;
  logic [7:0]  r;
  logic [7:0]  apins;
  int          errors;
  int          checks_done;
  int          n;
  // Half bit periods in clocks per clock select, and a level per pass.
  int          h [4] = '{1, 4, 16, 100};
  logic [7:0]  lv [4] = '{8'h3c, 8'h81, 8'hff, 8'h00};
  row_t        rows [19] = '{
    '{8'h1f, 8'h00, 0, 8'h00}, '{8'h0c, 8'h00, 0, 8'h00}, '{8'h0d, 8'h00, 0, 8'h00},
    '{8'h1e, 8'h00, 0, 8'h00}, '{8'h85, 8'h00, 0, 8'h3f}, '{8'h89, 8'h00, 0, 8'h07},
    '{8'h8c, 8'h00, 0, 8'h00}, '{8'h8d, 8'h00, 0, 8'h00}, '{8'h9f, 8'h00, 0, 8'h00},
    '{8'h0b, 8'h00, 0, 8'h00}, '{8'h05, 8'h00, 0, 8'h10}, '{8'h9f, 8'hff, 1, 8'h07},
    '{8'h05, 8'h00, 0, 8'h15}, '{8'h85, 8'hff, 1, 8'h3f}, '{8'h0b, 8'ha5, 1, 8'ha5},
    '{8'h40, 8'hff, 1, 8'h00}, '{8'h1f, 8'h04, 1, 8'h00}, '{8'h1f, 8'hc8, 1, 8'hc8},
    '{8'h8d, 8'hff, 1, 8'h01}};

  adc_event_trigger_control i_adc_event_trigger_control (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .compare_unit_two_mode_i(mode),
    .special_event_i(event_p), .timer_clear_o(tclr), .comparator_i(comp),
    .dac_code_o(dac), .input_channel_o(chan), .acquire_o(acq), .analog_pins_o(apins),
    .port_a_i(6'h15), .port_a_o(), .port_a_oe_o(), .port_e_i(3'h5), .port_e_o(),
    .port_e_oe_o(), .other_flags_i(oflags), .second_flag_i(sflag), .irq_o(irq));

  compare_unit_model i_compare_unit_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .enable_i(en), .period_i(16'h0040),
    .level_i(level), .timer_clear_i(tclr), .dac_code_i(dac),
    .special_event_o(event_p), .comparator_o(comp), .count_o(count));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each access opens on a fresh edge so a strobe is never lowered and raised at once.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic await(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 5000) begin
      @(posedge mclk_i);
      c++;
    end
    check(16'(c < 5000), 16'h0001, "wait bound");
  endtask

  task automatic fire;
    en <= 1'b1;
    await(event_p, 1'b1, n);
    en <= 1'b0;
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    #1200us;
    errors++;
    conclude();
  end

  initial begin
    {rst_i, addr, wdata, wr, rd, oflags, sflag, en, level} = {1'b1, 34'h0};
    mode = 4'hb;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, r);
      check(16'(r), 16'(rows[i].e), "register");
    end
    wr_reg(8'h9f, 8'h00);
    wr_reg(8'h8c, 8'h40);
    check(16'(apins), 16'h00ff, "analog pin map");
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h1f, {2'(s), 3'h5, 3'h1});
      level <= lv[s];
      repeat (20) @(posedge mclk_i);
      check(16'(chan), 16'h0005, "channel");
      fire();
      await(irq, 1'b1, n);
      check(16'(n >= 19 * h[s] && n <= 19 * h[s] + 6), 16'h0001, "length");
      check(count, 16'h0000, "timer restart");
      rd_reg(8'h1e, r);
      check(16'(r), 16'(lv[s]), "result");
      rd_reg(8'h1f, r);
      check(16'(r), 16'({2'(s), 3'h5, 3'h1}), "go cleared");
      rd_reg(8'h0c, r);
      check(16'(r), 16'h0040, "done flag");
      wr_reg(8'h0c, 8'h40);
      await(irq, 1'b0, n);
      check(16'(n <= 3), 16'h0001, "irq clear");
    end
    // A trigger refused with the converter off, or outside the special event mode, still restarts the timer.
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h1f, k == 0 ? 8'h28 : 8'h29);
      mode <= k == 0 ? 4'hb : 4'h8;
      fire();
      repeat (30) @(posedge mclk_i);
      check(count, 16'h0000, "refused timer restart");
      rd_reg(8'h1f, r);
      check(16'(r), k == 0 ? 16'h0028 : 16'h0029, "go untouched");
      check(16'(irq), 16'h0000, "no done");
    end
    mode <= 4'hb;
    level <= 8'hc3;
    wr_reg(8'h1f, 8'h69);
    fire();
    repeat (10) @(posedge mclk_i);
    wr_reg(8'h1f, 8'h69);
    await(acq, 1'b1, n);
    check(16'(n >= 16 && n <= 22), 16'h0001, "abort wait");
    rd_reg(8'h1e, r);
    check(16'(r), 16'h0000, "result kept");
    rd_reg(8'h0c, r);
    check(16'(r), 16'h0000, "no done after abort");
    wr_reg(8'h8c, 8'h00);
    wr_reg(8'h8d, 8'h00);
    @(posedge mclk_i);
    oflags <= 6'h01;
    sflag <= 1'b1;
    @(posedge mclk_i);
    oflags <= 6'h00;
    sflag <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check(16'(irq), 16'h0000, "masked irq");
    rd_reg(8'h0d, r);
    check(16'(r), 16'h0001, "second flag");
    wr_reg(8'h8c, 8'h01);
    await(irq, 1'b1, n);
    check(16'(n <= 3), 16'h0001, "unmasked irq");
    wr_reg(8'h8d, 8'h01);
    wr_reg(8'h0c, 8'h01);
    repeat (3) @(posedge mclk_i);
    check(16'(irq), 16'h0001, "second flag holds irq");
    wr_reg(8'h0d, 8'h01);
    await(irq, 1'b0, n);
    check(16'(n <= 3), 16'h0001, "all clear");
    conclude();
  end
endmodule // testbench
`default_nettype wire
